// ### src/exec_in_place_ctrl.v
// Execute-in-place mode control of a serial NOR flash, device side.
// Assumes the serial clock, chip select, data lines and reset pin come
// from outside the CLK domain, and the array answers ARRAY_DATA for
// ARRAY_ADDR within one CLK cycle.
`timescale 1ns/10ps
`default_nettype none
`include "exec_in_place_regs.vh"

module exec_in_place_ctrl (
	// System
	input  wire        CLK,
	input  wire        RST_N,
	// Serial link pins
	input  wire        SCK,
	input  wire        CS_N,
	input  wire [3:0]  DATA_IN,
	output reg  [3:0]  DATA_OUT,
	output reg  [3:0]  DATA_OE,
	input  wire        RESET_PIN_N,
	// Configuration
	input  wire [1:0]  PROTOCOL,
	input  wire [3:0]  DUMMY_CYCLES,
	input  wire        BASIC_VARIANT,
	input  wire        RESET_PIN_EN,
	input  wire [2:0]  NV_BOOT_MODE,
	input  wire        VCR_WR,
	input  wire        VCR_WDATA,
	// Array side
	input  wire [7:0]  ARRAY_DATA,
	output reg  [23:0] ARRAY_ADDR,
	// Status
	output reg         EXEC_IN_PLACE_MODE,
	output reg         VCR_ENABLE_BIT,
	output reg         READ_ACTIVE,
	output reg         RESET_PULSE
);

	// Frame phases. A frame outside the mode runs command, address,
	// dummy and data; a frame inside the mode skips the command phase.
	// Commands that carry no confirm bit park in the skip phase until
	// deselect, so only the reset pair is tracked for them.
	// The host may cut a frame at any point: deselect always returns the
	// sequencer to idle and drops the output enables, whatever the phase.
	//
	// Known limitation: a frame that ends before the first dummy clock
	// leaves the mode flag untouched, which is what recovery relies on
	// being different from a full frame with the confirm bit high.
	localparam S_IDLE  = 3'h0;
	localparam S_CMD   = 3'h1;
	localparam S_ADDR  = 3'h2;
	localparam S_DUMMY = 3'h3;
	localparam S_DATA  = 3'h4;
	localparam S_SKIP  = 3'h5;


	// Pin synchronisers, edge history and frame state.
	// The link clock is sampled, not used as a clock, so its half period
	// must span at least three CLK cycles for every edge to be seen.
	// Stage one of the synchroniser may go metastable; only stage two
	// is read by any logic below.
	reg  [6:0]  sync1_reg;
	reg  [6:0]  sync2_reg;
	reg         sck_prev_reg;
	reg         cs_prev_reg;
	reg  [2:0]  state_reg;
	reg  [1:0]  proto_reg;
	reg  [4:0]  cnt_reg;
	reg  [3:0]  dum_last_reg;
	reg  [23:0] in_reg;
	reg  [7:0]  out_sh_reg;
	reg  [2:0]  bcnt_reg;
	reg  [7:0]  cmd_reg;
	reg         cmd_whole_reg;
	reg         rst_en_reg;
	reg         load_cfg_reg;


	// Per-protocol decode, purely combinational from the latched protocol.
	// Latching the protocol at select keeps one frame on one lane width
	// even if the configuration port changes in mid-frame.
	reg  [4:0]  cmd_last;
	reg  [4:0]  addr_last;
	reg  [3:0]  oe_mask;
	reg  [23:0] shift_next;
	reg  [7:0]  cur_byte;
	reg  [7:0]  out_next;
	reg  [3:0]  lanes_out;
	reg  [2:0]  step;

	wire        sck_s    = sync2_reg[0];
	wire        cs_s     = sync2_reg[1];
	wire [3:0]  din_s    = sync2_reg[5:2];
	wire        rstpin_s = sync2_reg[6];
	wire        sck_rise = sck_s & ~sck_prev_reg;
	wire        sck_fall = ~sck_s & sck_prev_reg;
	wire        cs_fall  = ~cs_s & cs_prev_reg;
	wire        cs_rise  = cs_s & ~cs_prev_reg;
	// In quad the pin only acts while deselected
	wire        hw_rst   = RESET_PIN_EN & ~rstpin_s &
		((proto_reg != `PROTO_QUAD) | cs_s);

	// Fast read family, the only commands that carry a confirm bit.
	// Any other code sends the frame to the skip phase.
	function is_fast;
		input [7:0] code;
		begin
			is_fast = (code == `CMD_FAST_READ) || (code == `CMD_FAST_READ_DO) ||
				(code == `CMD_FAST_READ_DIO) || (code == `CMD_FAST_READ_QO) ||
				(code == `CMD_FAST_READ_QIO);
		end
	endfunction

	// Two-stage synchronisers; only stage two is looked at by logic
	always @(posedge CLK) begin
		if (!RST_N) begin
			sync1_reg    <= `SYNC_RESET;
			sync2_reg    <= `SYNC_RESET;
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b1;
		end else begin
			sync1_reg    <= {RESET_PIN_N, DATA_IN, CS_N, SCK};
			sync2_reg    <= sync1_reg;
			sck_prev_reg <= sck_s;
			cs_prev_reg  <= cs_s;
		end
	end

	// Lane width decode: shift-in, shift-out and phase lengths
	always @* begin
		cur_byte = (bcnt_reg == 3'h0) ? ARRAY_DATA : out_sh_reg;
		case (proto_reg)
			`PROTO_EXT: begin
				cmd_last   = `CMD_LAST_EXT;
				addr_last  = `ADDR_LAST_EXT;
				oe_mask    = `OE_EXT;
				step       = 3'h1;
				shift_next = {in_reg[22:0], din_s[0]};
				lanes_out  = {2'b00, cur_byte[7], 1'b0};
				out_next   = {cur_byte[6:0], 1'b0};
			end
			`PROTO_DUAL: begin
				cmd_last   = `CMD_LAST_DUAL;
				addr_last  = `ADDR_LAST_DUAL;
				oe_mask    = `OE_DUAL;
				step       = 3'h2;
				shift_next = {in_reg[21:0], din_s[1:0]};
				lanes_out  = {2'b00, cur_byte[7:6]};
				out_next   = {cur_byte[5:0], 2'b00};
			end
			default: begin
				cmd_last   = `CMD_LAST_QUAD;
				addr_last  = `ADDR_LAST_QUAD;
				oe_mask    = `OE_QUAD;
				step       = 3'h4;
				shift_next = {in_reg[19:0], din_s[3:0]};
				lanes_out  = cur_byte[7:4];
				out_next   = {cur_byte[3:0], 4'h0};
			end
		endcase
	end

	// Frame sequencer and mode flag; later assignments take priority,
	// so a hardware confirm event wins over a same-cycle VCR write
	always @(posedge CLK) begin
		if (!RST_N) begin
			state_reg          <= S_IDLE;
			proto_reg          <= `PROTO_EXT;
			cnt_reg            <= 5'h00;
			dum_last_reg       <= 4'h0;
			in_reg             <= 24'h000000;
			out_sh_reg         <= 8'h00;
			bcnt_reg           <= 3'h0;
			cmd_reg            <= 8'h00;
			cmd_whole_reg      <= 1'b0;
			rst_en_reg         <= 1'b0;
			load_cfg_reg       <= 1'b1;
			DATA_OUT           <= 4'h0;
			DATA_OE            <= 4'h0;
			ARRAY_ADDR         <= 24'h000000;
			EXEC_IN_PLACE_MODE <= 1'b0;
			VCR_ENABLE_BIT     <= 1'b1;
			READ_ACTIVE        <= 1'b0;
			RESET_PULSE        <= 1'b0;
		end else begin
			RESET_PULSE <= 1'b0;
			if (VCR_WR)
				VCR_ENABLE_BIT <= VCR_WDATA;
			// Boot field is caught after RST_N release, and again each cycle while the reset pin acts
			if (load_cfg_reg) begin
				EXEC_IN_PLACE_MODE <= (NV_BOOT_MODE != `NV_BOOT_OFF);
				VCR_ENABLE_BIT     <= (NV_BOOT_MODE == `NV_BOOT_OFF);
				load_cfg_reg       <= 1'b0;
			end
			if (hw_rst) begin
				load_cfg_reg  <= 1'b1;
				state_reg     <= S_IDLE;
				DATA_OE       <= 4'h0;
				READ_ACTIVE   <= 1'b0;
				rst_en_reg    <= 1'b0;
				cmd_whole_reg <= 1'b0;
			end else if (cs_rise) begin
				state_reg     <= S_IDLE;
				DATA_OE       <= 4'h0;
				READ_ACTIVE   <= 1'b0;
				cmd_whole_reg <= 1'b0;
				// Reset takes effect only at the deselect of the 99 frame
				if (cmd_whole_reg && (cmd_reg == `CMD_RESET_MEMORY) && rst_en_reg) begin
					load_cfg_reg <= 1'b1;
					RESET_PULSE  <= 1'b1;
					rst_en_reg   <= 1'b0;
				end else
					rst_en_reg <= cmd_whole_reg && (cmd_reg == `CMD_RESET_ENABLE);
			end else if (cs_fall) begin
				proto_reg     <= PROTOCOL;
				dum_last_reg  <= (DUMMY_CYCLES == 4'h0) ? 4'h0 : DUMMY_CYCLES - `DUMMY_MIN;
				cnt_reg       <= 5'h00;
				cmd_whole_reg <= 1'b0;
				// Mode flag survives deselect, so frames start at address
				state_reg     <= EXEC_IN_PLACE_MODE ? S_ADDR : S_CMD;
			end else if (sck_rise) begin
				case (state_reg)
					S_CMD: begin
						in_reg  <= shift_next;
						cnt_reg <= cnt_reg + 5'h01;
						if (cnt_reg == cmd_last) begin
							cmd_reg       <= shift_next[7:0];
							cmd_whole_reg <= 1'b1;
							cnt_reg       <= 5'h00;
							state_reg     <= is_fast(shift_next[7:0]) ? S_ADDR : S_SKIP;
						end
					end
					S_ADDR: begin
						in_reg  <= shift_next;
						cnt_reg <= cnt_reg + 5'h01;
						if (cnt_reg == addr_last) begin
							ARRAY_ADDR <= shift_next;
							cnt_reg    <= 5'h00;
							state_reg  <= S_DUMMY;
						end
					end
					S_DUMMY: begin
						cnt_reg <= cnt_reg + 5'h01;
						// Only line zero counts; the other lanes are don't care
						if (cnt_reg == 5'h00) begin
							if (!din_s[0]) begin
								if (EXEC_IN_PLACE_MODE || BASIC_VARIANT || !VCR_ENABLE_BIT)
									EXEC_IN_PLACE_MODE <= 1'b1;
							end else if (EXEC_IN_PLACE_MODE) begin
								// Host recovery lands here: all-ones address, then confirm
								EXEC_IN_PLACE_MODE <= 1'b0;
								VCR_ENABLE_BIT     <= 1'b1;
							end
						end
						if (cnt_reg == {1'b0, dum_last_reg}) begin
							cnt_reg   <= 5'h00;
							bcnt_reg  <= 3'h0;
							state_reg <= S_DATA;
						end
					end
					S_DATA, S_SKIP, S_IDLE: begin
						cnt_reg <= cnt_reg;
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end else if (sck_fall && (state_reg == S_DATA)) begin
				// Drive on falling edge so the host samples a settled value
				DATA_OUT    <= lanes_out;
				DATA_OE     <= oe_mask;
				READ_ACTIVE <= 1'b1;
				out_sh_reg  <= out_next;
				bcnt_reg    <= bcnt_reg + step;
				if (bcnt_reg == 3'h0)
					ARRAY_ADDR <= ARRAY_ADDR + 24'h000001;
			end
		end
	end

endmodule // exec_in_place_ctrl
`default_nettype wire

// ### src/exec_in_place_regs.vh
// Constants for the execute-in-place mode control of a serial flash.
// Included by exec_in_place_ctrl.v; holds definitions only.
`ifndef EXEC_IN_PLACE_REGS_VH
`define EXEC_IN_PLACE_REGS_VH

// Protocol codes on the PROTOCOL port
`define PROTO_EXT          2'h0
`define PROTO_DUAL         2'h1
`define PROTO_QUAD         2'h2

// Command codes
`define CMD_RESET_ENABLE   8'h66
`define CMD_RESET_MEMORY   8'h99
`define CMD_FAST_READ      8'h0B
`define CMD_FAST_READ_DO   8'h3B
`define CMD_FAST_READ_DIO  8'hBB
`define CMD_FAST_READ_QO   8'h6B
`define CMD_FAST_READ_QIO  8'hEB

// Nonvolatile boot field [11:9]; all ones means normal boot
`define NV_BOOT_OFF        3'h7

// Last clock index of command and address phases per protocol
`define CMD_LAST_EXT       5'h07
`define CMD_LAST_DUAL      5'h03
`define CMD_LAST_QUAD      5'h01
`define ADDR_LAST_EXT      5'h17
`define ADDR_LAST_DUAL     5'h0B
`define ADDR_LAST_QUAD     5'h05

// Output enable masks per protocol
`define OE_EXT             4'h2
`define OE_DUAL            4'h3
`define OE_QUAD            4'hF

// Synchroniser reset value and dummy count offset
`define SYNC_RESET         7'h42
`define DUMMY_MIN          4'h1

`endif

// ### testbench/xip_ctrl_asserts.sv
// Port checker for the execute-in-place control block.
// Assumes the 2-flop pin synchronisers and one CLK domain.
`timescale 1ns/10ps
`default_nettype none
module xip_ctrl_check (
	// System
	input wire logic       CLK,
	input wire logic       RST_N,
	// Link and configuration
	input wire logic       CS_N,
	input wire logic       RESET_PIN_N,
	input wire logic [1:0] PROTOCOL,
	input wire logic       BASIC_VARIANT,
	input wire logic       RESET_PIN_EN,
	input wire logic [2:0] NV_BOOT_MODE,
	input wire logic       VCR_WR,
	input wire logic       VCR_WDATA,
	// Watched outputs
	input wire logic [3:0] DATA_OE,
	input wire logic       EXEC_IN_PLACE_MODE,
	input wire logic       VCR_ENABLE_BIT,
	input wire logic       READ_ACTIVE,
	input wire logic       RESET_PULSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Boot field asks for the mode
	wire boot = NV_BOOT_MODE != 3'h7;
	property p_pulse; RESET_PULSE |=> !RESET_PULSE; endproperty
	property p_idle; CS_N [*6] |-> DATA_OE == 4'h0 && !READ_ACTIVE; endproperty
	property p_pin; (RESET_PIN_EN && !RESET_PIN_N && CS_N) [*6]
		|-> EXEC_IN_PLACE_MODE == boot && VCR_ENABLE_BIT != boot; endproperty
	property p_boot; $rose(RST_N) |=> EXEC_IN_PLACE_MODE == boot; endproperty
	// Pin low is seen late, so two past depths are allowed
	property p_keep; $changed(EXEC_IN_PLACE_MODE) |-> !CS_N || $past(RESET_PULSE)
		|| !($past(RESET_PIN_N, 3) && $past(RESET_PIN_N, 4)) || !$past(RST_N, 2); endproperty
	property p_wr; VCR_WR && CS_N && RESET_PIN_N |=> VCR_ENABLE_BIT == $past(VCR_WDATA);
	endproperty
	property p_exit; $fell(EXEC_IN_PLACE_MODE) |-> VCR_ENABLE_BIT; endproperty
	property p_enter; $rose(EXEC_IN_PLACE_MODE) && !CS_N
		|-> !VCR_ENABLE_BIT || BASIC_VARIANT; endproperty
	property p_oe; DATA_OE != 4'h0 |-> DATA_OE ==
		(PROTOCOL == 2'h0 ? 4'h2 : PROTOCOL == 2'h1 ? 4'h3 : 4'hF); endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	a_idle: assert property (p_idle) else $error("drive while deselected");
	a_pin: assert property (p_pin) else $error("pin reset state wrong");
	a_boot: assert property (p_boot) else $error("boot mode wrong");
	a_keep: assert property (p_keep) else $error("mode changed unprompted");
	a_wr: assert property (p_wr) else $error("config bit not written");
	a_exit: assert property (p_exit) else $error("exit left bit low");
	a_enter: assert property (p_enter) else $error("entry not armed");
	a_oe: assert property (p_oe) else $error("enables off protocol");
	c_enter: cover property ($rose(EXEC_IN_PLACE_MODE));
	c_exit: cover property ($fell(EXEC_IN_PLACE_MODE));
	c_soft: cover property (RESET_PULSE);
endmodule // xip_ctrl_check
bind exec_in_place_ctrl xip_ctrl_check chk (.CLK, .RST_N, .CS_N, .RESET_PIN_N, .PROTOCOL,
	.BASIC_VARIANT, .RESET_PIN_EN, .NV_BOOT_MODE, .VCR_WR, .VCR_WDATA, .DATA_OE,
	.EXEC_IN_PLACE_MODE, .VCR_ENABLE_BIT, .READ_ACTIVE, .RESET_PULSE);
`default_nettype wire

// ### testbench/flash_host.sv
// Serial host model framing reads and resets toward the flash block.
// Assumes the block samples the pins with its own faster clock.
`timescale 1ns/10ps
`default_nettype none
module flash_host (
	// Link pins
	output logic            SCK,
	output logic            CS_N,
	output logic [3:0]      DQ,
	input  wire logic [3:0] DQ_IN
);
	logic [7:0] rx;
	initial begin
		SCK = 1'b0;
		CS_N = 1'b1;
		DQ = 4'h5;
	end
	// Select with the clock parked low
	task sel;
		#400 CS_N = 1'b0;
	endtask
	// Top w bits each beat; read late in the high phase, the answer lags
	task send(input logic [31:0] v, input int n, input int w);
		for (int i = 0; i < n; i++) begin
			DQ = v[31:28] >> (4 - w);
			v = v << w;
			#400 SCK = 1'b1;
			#390 rx = {rx[6:0], DQ_IN[1]};
			#10 SCK = 1'b0;
		end
	endtask
	// Released lines flip so no stale level is mistaken for data
	task desel;
		#400 CS_N = 1'b1;
		DQ = ~DQ;
		#800;
	endtask
endmodule // flash_host
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the execute-in-place control block.
// Assumes the host model drives the link and the array is a lookup.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	logic        clk = 1'b0, rst_n = 1'b0, basic = 1'b0, pin_n = 1'b1, pin_en = 1'b1;
	logic        vcr_wr = 1'b0, vcr_wdata = 1'b1, sck, cs_n, mode, bit3, pulse;
	logic [1:0]  protocol = 2'h0;
	logic [2:0]  nv_boot = 3'h7;
	logic [3:0]  dq, dout, oe;
	logic [23:0] addr;
	int          mismatches = 0, compares = 0, pulses = 0;
	flash_host host (.SCK(sck), .CS_N(cs_n), .DQ(dq), .DQ_IN(dout));
	exec_in_place_ctrl dut (.CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n),
		.DATA_IN(dq), .DATA_OUT(dout), .DATA_OE(oe), .RESET_PIN_N(pin_n),
		.PROTOCOL(protocol), .DUMMY_CYCLES(4'h1), .BASIC_VARIANT(basic),
		.RESET_PIN_EN(pin_en), .NV_BOOT_MODE(nv_boot), .VCR_WR(vcr_wr),
		.VCR_WDATA(vcr_wdata), .ARRAY_DATA(addr[7:0] ^ 8'hA5), .ARRAY_ADDR(addr),
		.EXEC_IN_PLACE_MODE(mode), .VCR_ENABLE_BIT(bit3), .READ_ACTIVE(),
		.RESET_PULSE(pulse));
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (pulse === 1'b1) pulses++;
	task cyc(input int n); repeat (n) @(posedge clk); endtask
	task state(input logic m, input logic b); `CHK(mode, m) `CHK(bit3, b) endtask
	task pin_reset; @(posedge clk) pin_n <= 1'b0; cyc(6); pin_n <= 1'b1; cyc(4); endtask
	task set_vcr(input logic v);
		@(posedge clk) begin vcr_wdata <= v; vcr_wr <= 1'b1; end
		@(posedge clk) vcr_wr <= 1'b0;
		cyc(2);
	endtask
	// Fast read or address-only read with a confirm bit and one data byte
	task xread(input logic [23:0] a, input logic cmd, input logic c);
		host.sel;
		if (cmd) host.send(32'h0B000000, 8, 1);
		host.send({a, 8'h00}, 24, 1);
		host.send({c, 31'h0}, 1, 1);
		host.send(32'h0, 8, 1);
		host.desel;
		`CHK(host.rx, a[7:0] ^ 8'hA5)
	endtask
	task conclude;
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin #3000000; mismatches++; conclude; end
	initial begin
		cyc(2); rst_n <= 1'b1; cyc(4);
		state(1'b0, 1'b1);
		nv_boot <= 3'h2; pin_reset; state(1'b1, 1'b0);
		nv_boot <= 3'h7; pin_reset; state(1'b0, 1'b1);
		$display("Test boot and pin reset done");
		set_vcr(1'b0); state(1'b0, 1'b0);
		xread(24'h00012C, 1'b1, 1'b0); state(1'b1, 1'b0);
		xread(24'h000241, 1'b0, 1'b0); state(1'b1, 1'b0);
		xread(24'h000300, 1'b0, 1'b1); state(1'b0, 1'b1);
		$display("Test arm, enter and leave done");
		@(posedge clk) basic <= 1'b1;
		xread(24'h00007F, 1'b1, 1'b0); state(1'b1, 1'b1);
		@(posedge clk) protocol <= 2'h1;
		host.sel; host.send(32'h00012300, 12, 2); host.send(32'h80000000, 1, 2);
		host.send(32'h0, 4, 2); host.desel;
		state(1'b1, 1'b1);
		@(posedge clk) pin_en <= 1'b0;
		pin_reset; state(1'b1, 1'b1);
		@(posedge clk) pin_en <= 1'b1;
		@(posedge clk) protocol <= 2'h2;
		host.sel; host.send(32'hFFFFFFFF, 7, 1); host.desel;
		state(1'b0, 1'b1);
		$display("Test basic entry and recovery done");
		@(posedge clk) begin protocol <= 2'h0; basic <= 1'b0; end
		set_vcr(1'b0);
		host.sel; host.send(32'h66000000, 8, 1); host.desel;
		host.sel; host.send(32'h99000000, 8, 1); host.desel;
		state(1'b0, 1'b1);
		`CHK(pulses, 1)
		$display("Test soft reset done");
		conclude;
	end
endmodule // testbench
`default_nettype wire
